// file: common/hsrl_pkg.sv
// Constants and types for the host port strobe and ready logic
package hsrl_pkg;

  // Register select codes on the host pins
  localparam logic [1:0] SEL_CTRL = 2'h0;
  localparam logic [1:0] SEL_DATA_INC = 2'h1;
  localparam logic [1:0] SEL_ADDR = 2'h2;
  localparam logic [1:0] SEL_DATA_FIX = 2'h3;

  // Values after reset
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  localparam logic [31:0] DATA_RST = 32'h0000_0000;

  // Address step of an auto-incrementing access, in bytes
  localparam logic [31:0] ADDR_STEP = 32'h0000_0004;

  // Host strobe minimum widths, in ref_clk cycles
  localparam int STROBE_LOW_MIN_CYC = 2;
  localparam int STROBE_HIGH_MIN_CYC = 2;

  // Port sequencer states, one bit per step except ST_RD_SETTLE to ST_IDLE and ST_IDLE to and from ST_WR_WAIT
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RD_WAIT = 3'h1,
    ST_RD_SETTLE = 3'h3,
    ST_INCR = 3'h2,
    ST_WR_WAIT = 3'h6
  } hsrl_state_t;

endpackage : hsrl_pkg

// file: sim/hsrl_aux_mem.sv
// Behavioural memory on the far side of the auxiliary channel
`timescale 1ns/1ps
`default_nettype none
module hsrl_aux_mem (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Answer pace, high for a slow memory
  input wire logic slow,
  // Auxiliary channel
  input wire logic aux_req,
  input wire logic aux_write,
  input wire logic [31:0] aux_addr,
  input wire logic [31:0] aux_wdata,
  output logic aux_ack,
  output logic [31:0] aux_rdata
);
  logic [31:0] mem [16];
  logic [4:0] wait_reg;
  logic done_reg;
  ////////////////////////////////////////////////////////////
  // Request stays up a cycle past the ack, so done_reg blocks a second answer
  // Read data toggles outside the ack so a stale word never looks valid
  always_ff @(posedge ref_clk) begin
    aux_ack <= 1'b0;
    aux_rdata <= ~aux_rdata;
    wait_reg <= aux_req ? wait_reg + 5'h01 : 5'h00;
    if (!aux_req) done_reg <= 1'b0;
    if (!rst_n) begin
      done_reg <= 1'b0;
      wait_reg <= 5'h00;
      aux_rdata <= 32'h0000_0000;
      for (int i = 0; i < 16; i++) mem[i] <= 32'hA5A5_0000 + 32'(i);
    end else if (aux_req && !done_reg && wait_reg >= (slow ? 5'h14 : 5'h01)) begin
      aux_ack <= 1'b1;
      done_reg <= 1'b1;
      if (aux_write) mem[aux_addr[5:2]] <= aux_wdata;
      else aux_rdata <= mem[aux_addr[5:2]];
    end
  end
endmodule : hsrl_aux_mem
`default_nettype wire

// file: sim/hsrl_host_port_tb.sv
// Testbench for the host port strobe and ready logic
`timescale 1ns/1ps
`default_nettype none
module hsrl_host_port_tb;
  typedef struct {logic [1:0] sel; logic rw; logic hw; logic has; logic [15:0] d;} hsrl_row_t;
  logic ref_clk = 0, rst_n = 0, cs_n = 0, sa = 0, sb = 0, has_n = 1, rw = 0, hw = 0, slow = 0;
  logic [1:0] rs = 2'h0;
  logic [15:0] din = 16'h0000, dout;
  logic oe, ready_n, req, wr, ack;
  logic [31:0] addr, wdata, rdata;
  int fail_count = 0, num_checks = 0, cyc = 0, busy_cyc = 0;
  hsrl_row_t rows [15] = '{
    '{2'h2, 1'h0, 1'h0, 1'h0, 16'h0008}, '{2'h2, 1'h0, 1'h1, 1'h0, 16'h0000},
    '{2'h3, 1'h0, 1'h0, 1'h0, 16'h1234}, '{2'h3, 1'h0, 1'h1, 1'h0, 16'hABCD},
    '{2'h3, 1'h1, 1'h0, 1'h0, 16'h1234}, '{2'h3, 1'h1, 1'h1, 1'h0, 16'hABCD},
    '{2'h2, 1'h1, 1'h0, 1'h1, 16'h0008}, '{2'h1, 1'h0, 1'h0, 1'h0, 16'h5555},
    '{2'h1, 1'h0, 1'h1, 1'h0, 16'h6666}, '{2'h2, 1'h1, 1'h0, 1'h0, 16'h000C},
    '{2'h1, 1'h1, 1'h0, 1'h0, 16'h0003}, '{2'h1, 1'h1, 1'h1, 1'h0, 16'hA5A5},
    '{2'h2, 1'h1, 1'h0, 1'h0, 16'h0010}, '{2'h0, 1'h0, 1'h0, 1'h0, 16'h5A3C},
    '{2'h0, 1'h1, 1'h0, 1'h0, 16'h5A3C}};
  ////////////////////////////////////////////////////////////
  hsrl_host_port dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .host_chip_select_n(cs_n),
    .host_data_strobe_a(sa), .host_data_strobe_b(sb), .host_addr_strobe_n(has_n),
    .host_register_select(rs), .host_read_write(rw), .half_word_identifier(hw),
    .host_data_bus_in(din), .host_data_bus_out(dout), .host_data_bus_oe(oe),
    .host_ready_n(ready_n), .aux_req(req), .aux_write(wr), .aux_addr(addr),
    .aux_wdata(wdata), .aux_ack(ack), .aux_rdata(rdata));
  hsrl_aux_mem mem_u (.ref_clk(ref_clk), .rst_n(rst_n), .slow(slow), .aux_req(req),
    .aux_write(wr), .aux_addr(addr), .aux_wdata(wdata), .aux_ack(ack), .aux_rdata(rdata));
  ////////////////////////////////////////////////////////////
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (ready_n === 1'b1) busy_cyc++;
    if (cyc == 3000) begin
      fail_count++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  task automatic check(input bit ok, input string m);
    num_checks++;
    if (!ok) begin
      fail_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : check
  // Host keeps the strobe low until ready falls, for at most 100 cycles
  task automatic wait_ready();
    for (int n = 0; n < 100 && ready_n !== 1'b0; n++) @(negedge ref_clk);
  endtask : wait_ready
  task automatic access(input hsrl_row_t r, input bit alt, input bit fin);
    logic busy_exp;
    int busy_start;
    busy_exp = r.sel[0] && ((r.rw && !r.hw) || (r.hw && (!r.rw || r.sel == 2'h1)));
    busy_start = busy_cyc;
    {rs, rw, hw} = {r.sel, r.rw, r.hw};
    din = ~r.d;
    has_n = !r.has;
    // Selects go wrong once the address strobe has taken them
    if (r.has) @(negedge ref_clk);
    if (r.has) {rs, rw, hw} = {r.sel ^ 2'h3, !r.rw, !r.hw};
    {sa, sb} = {alt, !alt};
    repeat (2) @(negedge ref_clk);
    wait_ready();
    din = r.d;
    if (r.rw) check(dout === r.d && oe === 1'b1, "read data");
    @(negedge ref_clk);
    {sb, has_n} = {alt, 1'b1};
    if (fin) begin
      repeat (2) @(negedge ref_clk);
      if (r.rw) check(oe === 1'b0, "bus not released");
      wait_ready();
      check((busy_cyc != busy_start) === busy_exp, "busy flag");
    end
  endtask : access
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(negedge ref_clk);
    check(ready_n === 1'b0 && oe === 1'b0 && req === 1'b0, "after reset");
    rst_n = 1'b1;
    foreach (rows[i]) access(rows[i], i % 2, 1'b1);
    check(mem_u.mem[2] === 32'h6666_5555, "stored word");
    // Chip-select high keeps the strobe off even with strobes that differ
    {cs_n, sa, sb, rs, rw, hw} = {1'b1, 1'b1, 1'b0, 2'h3, 1'b1, 1'b0};
    repeat (4) @(negedge ref_clk);
    check(req === 1'b0 && oe === 1'b0, "strobe formed");
    {cs_n, sb} = {1'b0, 1'b1};
    slow = 1'b1;
    access('{2'h3, 1'h0, 1'h1, 1'h0, 16'hBEEF}, 1'b0, 1'b0);
    cs_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    check(ready_n === 1'b0, "ready not gated");
    cs_n = 1'b0;
    @(negedge ref_clk);
    check(ready_n === 1'b1, "busy hidden");
    wait_ready();
    repeat (2) @(negedge ref_clk);
    check(mem_u.mem[4] === 32'hBEEF_0003, "slow write");
    // Reset in mid-read; strobe back high by release so no false edge follows
    {sa, rw, hw} = {1'b1, 1'b1, 1'b0};
    repeat (3) @(negedge ref_clk);
    check(ready_n === 1'b1 && req === 1'b1 && oe === 1'b1, "read not started");
    {rst_n, sa} = {1'b0, 1'b0};
    repeat (2) @(negedge ref_clk);
    check(ready_n === 1'b0 && req === 1'b0 && oe === 1'b0, "mid-run reset");
    rst_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    check(ready_n === 1'b0 && req === 1'b0 && ack === 1'b0, "busy after reset");
    final_report();
  end
endmodule : hsrl_host_port_tb
`default_nettype wire

// file: verilog/hsrl_host_port.sv
// Host port: strobe forming, select capture, half-word data and ready handshake
`timescale 1ns/1ps
`default_nettype none

module hsrl_host_port (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Host strobes and selects
  input wire logic host_chip_select_n,
  input wire logic host_data_strobe_a,
  input wire logic host_data_strobe_b,
  input wire logic host_addr_strobe_n,
  input wire logic [1:0] host_register_select,
  input wire logic host_read_write,
  input wire logic half_word_identifier,
  // Host data bus, split into its three signals
  input wire logic [15:0] host_data_bus_in,
  output logic [15:0] host_data_bus_out,
  output logic host_data_bus_oe,
  // Host ready, high while the port is busy and chip-select is low
  output logic host_ready_n,
  // Auxiliary memory channel
  output logic aux_req,
  output logic aux_write,
  output logic [31:0] aux_addr,
  output logic [31:0] aux_wdata,
  input wire logic aux_ack,
  input wire logic [31:0] aux_rdata
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  hsrl_pkg::hsrl_state_t state_reg, state_next;
  logic strobe_q_reg;
  logic has_q_reg;
  logic [1:0] sel_reg, sel_next;
  logic rw_reg, rw_next;
  logic hw_reg, hw_next;
  logic [15:0] ctrl_reg, ctrl_next;
  logic [31:0] addr_reg, addr_next;
  logic [31:0] data_reg, data_next;
  logic [15:0] dout_reg, dout_next;
  logic oe_reg, oe_next;
  logic ready_n_reg, ready_n_next;
  logic req_reg, req_next;
  logic wr_reg, wr_next;

  ////////////////////////////////////////////////////////////////////////////
  // Strobe forming and edge detection
  wire strobe_n_w = ~(host_data_strobe_a ^ host_data_strobe_b) | host_chip_select_n;
  wire strobe_fall = strobe_q_reg & ~strobe_n_w;
  wire strobe_rise = ~strobe_q_reg & strobe_n_w;
  wire has_fall = has_q_reg & ~host_addr_strobe_n;

  // Address strobe tied high means the access strobe does the capture
  wire load_sel = has_fall | (strobe_fall & host_addr_strobe_n);
  wire [1:0] eff_sel = host_addr_strobe_n ? host_register_select : sel_reg;
  wire eff_rw = host_addr_strobe_n ? host_read_write : rw_reg;
  wire eff_hw = host_addr_strobe_n ? half_word_identifier : hw_reg;
  wire eff_data = (eff_sel == hsrl_pkg::SEL_DATA_INC) | (eff_sel == hsrl_pkg::SEL_DATA_FIX);
  wire reg_data = (sel_reg == hsrl_pkg::SEL_DATA_INC) | (sel_reg == hsrl_pkg::SEL_DATA_FIX);
  wire reg_inc = (sel_reg == hsrl_pkg::SEL_DATA_INC);
  wire idle = (state_reg == hsrl_pkg::ST_IDLE);

  // Access classes
  wire rd_first = strobe_fall & eff_rw & eff_data & ~eff_hw & idle;
  wire wr_any = strobe_rise & ~rw_reg;
  wire wr_last = wr_any & hw_reg & reg_data & idle;
  wire rd_inc_last = strobe_rise & rw_reg & hw_reg & reg_inc & idle;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      hsrl_pkg::ST_IDLE: begin
        if (rd_first) begin
          state_next = hsrl_pkg::ST_RD_WAIT;
        end else if (wr_last) begin
          state_next = hsrl_pkg::ST_WR_WAIT;
        end else if (rd_inc_last) begin
          state_next = hsrl_pkg::ST_INCR;
        end
      end
      hsrl_pkg::ST_RD_WAIT: begin
        if (aux_ack) begin
          state_next = hsrl_pkg::ST_RD_SETTLE;
        end
      end
      // One extra busy cycle so read data leads the ready fall
      hsrl_pkg::ST_RD_SETTLE: state_next = hsrl_pkg::ST_IDLE;
      hsrl_pkg::ST_WR_WAIT: begin
        if (aux_ack) begin
          state_next = reg_inc ? hsrl_pkg::ST_INCR : hsrl_pkg::ST_IDLE;
        end
      end
      hsrl_pkg::ST_INCR: state_next = hsrl_pkg::ST_IDLE;
      default: state_next = hsrl_pkg::ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Selects, registers and data path
  assign sel_next = load_sel ? host_register_select : sel_reg;
  assign rw_next = load_sel ? host_read_write : rw_reg;
  assign hw_next = load_sel ? half_word_identifier : hw_reg;

  wire wr_ctrl = wr_any & (sel_reg == hsrl_pkg::SEL_CTRL);
  wire wr_addr = wr_any & (sel_reg == hsrl_pkg::SEL_ADDR);
  wire wr_data = wr_any & reg_data & idle;
  wire rd_load = (state_reg == hsrl_pkg::ST_RD_WAIT) & aux_ack;

  assign ctrl_next = wr_ctrl ? host_data_bus_in : ctrl_reg;

  always_comb begin
    addr_next = addr_reg;
    if (state_reg == hsrl_pkg::ST_INCR) begin
      addr_next = addr_reg + hsrl_pkg::ADDR_STEP;
    end else if (wr_addr & hw_reg) begin
      addr_next = {host_data_bus_in, addr_reg[15:0]};
    end else if (wr_addr) begin
      addr_next = {addr_reg[31:16], host_data_bus_in};
    end
  end

  always_comb begin
    data_next = data_reg;
    if (rd_load) begin
      data_next = aux_rdata;
    end else if (wr_data & hw_reg) begin
      data_next = {host_data_bus_in, data_reg[15:0]};
    end else if (wr_data) begin
      data_next = {data_reg[31:16], host_data_bus_in};
    end
  end

  // Mux from next values, so the data flop moves with the word it shows
  wire [31:0] word_sel = (sel_next == hsrl_pkg::SEL_ADDR) ? addr_next : data_next;
  wire [15:0] half_sel = hw_next ? word_sel[31:16] : word_sel[15:0];
  assign dout_next = (sel_next == hsrl_pkg::SEL_CTRL) ? ctrl_next : half_sel;

  // Drivers on after a read strobe falls, off once it rises
  assign oe_next = strobe_rise ? 1'b0 : ((strobe_fall & eff_rw) | oe_reg);

  // Ready follows the sequencer, gated by chip-select
  assign ready_n_next = ~host_chip_select_n & (state_next != hsrl_pkg::ST_IDLE);

  assign req_next = (state_next == hsrl_pkg::ST_RD_WAIT) |
    (state_next == hsrl_pkg::ST_WR_WAIT);
  assign wr_next = (state_next == hsrl_pkg::ST_WR_WAIT);

  ////////////////////////////////////////////////////////////////////////////
  // Flops
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg <= hsrl_pkg::ST_IDLE;
      strobe_q_reg <= 1'b1;
      has_q_reg <= 1'b1;
      sel_reg <= hsrl_pkg::SEL_CTRL;
      rw_reg <= 1'b0;
      hw_reg <= 1'b0;
      ctrl_reg <= hsrl_pkg::CTRL_RST;
      addr_reg <= hsrl_pkg::ADDR_RST;
      data_reg <= hsrl_pkg::DATA_RST;
    end else begin
      state_reg <= state_next;
      strobe_q_reg <= strobe_n_w;
      has_q_reg <= host_addr_strobe_n;
      sel_reg <= sel_next;
      rw_reg <= rw_next;
      hw_reg <= hw_next;
      ctrl_reg <= ctrl_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dout_reg <= 16'h0000;
      oe_reg <= 1'b0;
      ready_n_reg <= 1'b0;
      req_reg <= 1'b0;
      wr_reg <= 1'b0;
    end else begin
      dout_reg <= dout_next;
      oe_reg <= oe_next;
      ready_n_reg <= ready_n_next;
      req_reg <= req_next;
      wr_reg <= wr_next;
    end
  end

  assign host_data_bus_out = dout_reg;
  assign host_data_bus_oe = oe_reg;
  assign host_ready_n = ready_n_reg;
  assign aux_req = req_reg;
  assign aux_write = wr_reg;
  assign aux_addr = addr_reg;
  assign aux_wdata = data_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_ready_cs_gate: assert property (
    host_chip_select_n |=> !host_ready_n)
    else $error("ready high while chip-select high");

  a_busy_on_cs: assert property (
    $fell(host_chip_select_n) && !idle |=> host_ready_n)
    else $error("busy not shown when chip-select fell");

  a_read_request: assert property (
    rd_first && !host_chip_select_n |=> aux_req && !aux_write && host_ready_n)
    else $error("first half read did not request word");

  a_read_hold: assert property (
    aux_req && !aux_write && !aux_ack && !host_chip_select_n |=> host_ready_n)
    else $error("ready fell before word loaded");

  a_autoinc_busy: assert property (
    rd_inc_last && !host_chip_select_n |=> host_ready_n && state_reg == hsrl_pkg::ST_INCR)
    else $error("incrementing read not held busy");

  a_write_busy: assert property (
    wr_last && !host_chip_select_n |=> host_ready_n && aux_req && aux_write ##1 host_ready_n)
    else $error("second half write not held busy");

  a_other_no_busy: assert property (
    idle && strobe_fall && !rd_first && !host_chip_select_n |=> !host_ready_n)
    else $error("ready raised by a non-data access");

  a_write_latch: assert property (
    wr_data && !hw_reg |=> data_reg[15:0] == $past(host_data_bus_in))
    else $error("write data not latched on strobe rise");

  a_data_lead: assert property (
    $fell(host_ready_n) && host_data_bus_oe |-> $stable(host_data_bus_out))
    else $error("read data changed as ready fell");

  a_oe_release: assert property (
    strobe_rise |=> !host_data_bus_oe)
    else $error("drivers not released after strobe rise");

  a_sel_capture: assert property (
    has_fall |=> sel_reg == $past(host_register_select) && rw_reg == $past(host_read_write))
    else $error("selects not taken on address strobe fall");

  c_read_word: cover property (rd_first ##[1:40] $fell(host_ready_n));
  c_write_word: cover property (wr_last ##[1:40] state_reg == hsrl_pkg::ST_INCR);
  c_has_used: cover property (has_fall ##[1:10] strobe_fall);

endmodule : hsrl_host_port

`default_nettype wire
